/* File: core/udirq_pkg.sv */
// Constants for the USB device interrupt enable, status and clear block.
// Assumes a 32-bit APB register bus and a 200 MHz controller clock.
package udirq_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] IEN_ADDR = 32'hF803C010;
  localparam logic [31:0] FLAGS_ADDR = 32'hF803C014;
  localparam logic [31:0] CLEAR_ADDR = 32'hF803C018;
  localparam logic [31:0] EPRST_ADDR = 32'hF803C01C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SPEED = 0;
  localparam int BIT_SUSPEND = 1;
  localparam int BIT_USOF = 2;
  localparam int BIT_SOF = 3;
  localparam int BIT_RSTDONE = 4;
  localparam int BIT_WAKE = 5;
  localparam int BIT_HRESUME = 6;
  localparam int BIT_RRESUME = 7;
  localparam int EP_LSB = 8;
  localparam int EP_NUM = 7;
  localparam int DMA_LSB = 25;
  localparam int DMA_NUM = 6;
  localparam int FRAME_W = 11;
  localparam int UFRM_W = 3;

  // ----------------------------------------------------------------
  // masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] IEN_MASK = 32'h7E00_7FFE;
  localparam logic [31:0] EVENT_MASK = 32'h0000_00FE;
  localparam logic [31:0] IEN_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 200000;
  localparam int SUSPEND_MS = 3;
  localparam int SUSPEND_CYCLES = SUSPEND_MS * CLK_KHZ;
  localparam int SUSP_CNT_W = 20;

  typedef enum logic {
    LINK_ACTIVE,
    LINK_SUSPENDED
  } udirq_link_type;

endpackage : udirq_pkg

/* File: core/udirq_ctrl.sv */
// USB device interrupt enable, status, clear and endpoint reset strobes.
// Assumes an APB master on mclk_i and protocol logic on the same clock;
// line_j_i is a raw pin, wake_activity_i a filtered non-idle line pulse.
//
// Function
// - bus reset clears enables; software writes them
// - enable of reset-done set after bus reset
// - speed bit reads high-speed mode
// - suspend flag after 3 ms idle J
// - flag raises interrupt only when enabled
// - microframe start flag, received ones increment index
// - frame start flag; received one updates frame, clears index in high speed
// - never both start flags on one event
// - reset-done flag at bus reset end
// - wake flag from line activity while suspended
// - wake detection works without controller clock
// - host resume end sets its flag
// - upstream resume sets flag while sending
// - endpoint summaries follow enabled sources
// - channel summaries follow enabled sources
// - clear register ones clear event flags
// - status read-only; summaries clear at source
// - endpoint reset register pulses endpoint reset
`timescale 1ns/1ps
`default_nettype none

module udirq_ctrl #(
  parameter int SUSPEND_CYCLES = udirq_pkg::SUSPEND_CYCLES
) (
  input wire logic mclk_i,                  // controller clock
  input wire logic nrst_i,                  // synchronous reset, low
  input wire logic psel_i,                  // apb select
  input wire logic penable_i,               // apb enable
  input wire logic pwrite_i,                // apb write
  input wire logic [31:0] paddr_i,          // apb byte address
  input wire logic [31:0] pwdata_i,         // apb write data
  output logic [31:0] prdata_o,             // apb read data
  output logic pready_o,                    // apb ready
  output logic pslverr_o,                   // apb error, unmapped
  input wire logic high_speed_i,            // controller in high speed
  input wire logic bus_reset_i,             // bus reset in progress
  input wire logic line_j_i,                // raw pin: line in j
  input wire logic wake_activity_i,         // filtered non-idle edge
  input wire logic sof_detect_i,            // frame sof received
  input wire logic sof_synth_i,             // frame sof synthesised
  input wire logic usof_detect_i,           // microframe sof received
  input wire logic usof_synth_i,            // microframe sof synthesised
  input wire logic [10:0] frame_number_i,   // frame field of sof
  input wire logic host_resume_done_i,      // host resume ended, pulse
  input wire logic remote_resume_sending_i, // upstream resume driven
  input wire logic [6:0] ep_irq_src_i,      // endpoint sources
  input wire logic [5:0] dma_irq_src_i,     // channel 1..6 sources
  output logic irq_o,                       // controller interrupt
  output logic wake_irq_o,                  // wake request, clockless
  output logic [6:0] ep_reset_o,            // endpoint reset pulses
  output logic suspended_o,                 // link suspended
  output logic [2:0] ufrm_index_o,          // microframe index
  output logic [10:0] frame_count_o         // last frame number
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  logic [31:0] ien;
  logic [31:0] flags;
  logic [6:0] ep_sum;
  logic [5:0] dma_sum;
  logic wr_en;
  logic rd_setup;
  logic bus_reset_q;
  logic reset_end;
  udirq_pkg::udirq_link_type link_state;
  logic [udirq_pkg::SUSP_CNT_W-1:0] idle_cnt;
  logic line_j_s1;
  logic line_j_s2;
  logic wake_tgl;
  logic wake_s1;
  logic wake_s2;
  logic wake_seen;
  logic wake_event;
  logic sof_event;
  logic usof_event;
  logic suspend_event;
  logic [31:0] next_flags;
  logic [31:0] status_view;
  logic [31:0] clr_bits;

  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_setup = psel_i & ~penable_i;

  // no wait state: read data is registered in the setup phase, so it comes from a flop
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      pready_o <= 1'b0;
    else
      pready_o <= rd_setup;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (rd_setup)
    begin
      pslverr_o <= 1'b0;
      if (hit(paddr_i, udirq_pkg::IEN_ADDR))
        prdata_o <= pwrite_i ? 32'h0000_0000 : ien;
      else if (hit(paddr_i, udirq_pkg::FLAGS_ADDR))
        prdata_o <= pwrite_i ? 32'h0000_0000 : status_view;
      else if (hit(paddr_i, udirq_pkg::CLEAR_ADDR))
        prdata_o <= 32'h0000_0000;
      else if (hit(paddr_i, udirq_pkg::EPRST_ADDR))
        prdata_o <= 32'h0000_0000;
      else
      begin
        prdata_o <= 32'h0000_0000;
        pslverr_o <= 1'b1;
      end
    end
    else
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus reset tracking
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      bus_reset_q <= 1'b0;
    else
      bus_reset_q <= bus_reset_i;
  end

  assign reset_end = bus_reset_q & ~bus_reset_i;

  // ----------------------------------------------------------------
  // interrupt enable register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      ien <= udirq_pkg::IEN_RESET;
    else if (bus_reset_i)
      ien <= udirq_pkg::IEN_RESET;
    else if (reset_end)
      ien <= udirq_pkg::IEN_RESET | (32'h1 << udirq_pkg::BIT_RSTDONE);
    else if (wr_en && hit(paddr_i, udirq_pkg::IEN_ADDR))
      ien <= pwdata_i & udirq_pkg::IEN_MASK;
  end

  // ----------------------------------------------------------------
  // suspend detection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      line_j_s1 <= 1'b0;
      line_j_s2 <= 1'b0;
    end
    else
    begin
      line_j_s1 <= line_j_i;
      line_j_s2 <= line_j_s1;
    end
  end

  // counter stops at the threshold, so one flag per idle period
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      idle_cnt <= '0;
    else if (!line_j_s2 || bus_reset_i)
      idle_cnt <= '0;
    else if (idle_cnt != udirq_pkg::SUSP_CNT_W'(SUSPEND_CYCLES))
      idle_cnt <= idle_cnt + 1'b1;
  end

  assign suspend_event = line_j_s2 && !bus_reset_i
    && (idle_cnt == udirq_pkg::SUSP_CNT_W'(SUSPEND_CYCLES - 1));

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      link_state <= udirq_pkg::LINK_ACTIVE;
    else
    begin
      case (link_state)
        udirq_pkg::LINK_ACTIVE:
          if (suspend_event)
            link_state <= udirq_pkg::LINK_SUSPENDED;
        udirq_pkg::LINK_SUSPENDED:
          if (!line_j_s2 || bus_reset_i)
            link_state <= udirq_pkg::LINK_ACTIVE;
        default:
          link_state <= udirq_pkg::LINK_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      suspended_o <= 1'b0;
    else
      suspended_o <= (link_state == udirq_pkg::LINK_SUSPENDED);
  end

  // ----------------------------------------------------------------
  // wake capture, clocked by line activity itself
  // ----------------------------------------------------------------
  // runs with mclk_i stopped; suspended_o and the resume level are
  // static while the controller clock is off
  // reset is asynchronous here: no activity edge may come to sample it
  always_ff @(posedge wake_activity_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wake_tgl <= 1'b0;
    else if (suspended_o && !remote_resume_sending_i)
      wake_tgl <= ~wake_tgl;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_seen <= 1'b0;
    end
    else
    begin
      wake_s1 <= wake_tgl;
      wake_s2 <= wake_s1;
      wake_seen <= wake_s2;
    end
  end

  assign wake_event = wake_s2 ^ wake_seen;

  // the only output not from a flop: it must act with no clock
  assign wake_irq_o = ((wake_tgl ^ wake_seen) | flags[udirq_pkg::BIT_WAKE])
    & ien[udirq_pkg::BIT_WAKE];

  // ----------------------------------------------------------------
  // start of frame events and frame counters
  // ----------------------------------------------------------------
  assign sof_event = sof_detect_i | sof_synth_i;
  // a frame start takes precedence over a microframe start
  assign usof_event = (usof_detect_i | usof_synth_i) & ~sof_event;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i || bus_reset_i)
    begin
      ufrm_index_o <= '0;
      frame_count_o <= '0;
    end
    else if (sof_detect_i)
    begin
      frame_count_o <= frame_number_i;
      if (high_speed_i)
        ufrm_index_o <= '0;
    end
    else if (usof_detect_i)
      ufrm_index_o <= ufrm_index_o + 1'b1;
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  assign clr_bits = (wr_en && hit(paddr_i, udirq_pkg::CLEAR_ADDR))
    ? (pwdata_i & udirq_pkg::EVENT_MASK) : 32'h0000_0000;

  // set wins over a clear in the same cycle
  always_comb
  begin
    next_flags = flags & ~clr_bits;
    if (suspend_event)
      next_flags[udirq_pkg::BIT_SUSPEND] = 1'b1;
    if (usof_event)
      next_flags[udirq_pkg::BIT_USOF] = 1'b1;
    if (sof_event)
      next_flags[udirq_pkg::BIT_SOF] = 1'b1;
    if (reset_end)
      next_flags[udirq_pkg::BIT_RSTDONE] = 1'b1;
    if (wake_event)
      next_flags[udirq_pkg::BIT_WAKE] = 1'b1;
    if (host_resume_done_i)
      next_flags[udirq_pkg::BIT_HRESUME] = 1'b1;
    if (remote_resume_sending_i)
      next_flags[udirq_pkg::BIT_RRESUME] = 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      flags <= udirq_pkg::FLAGS_RESET;
    else
      flags <= next_flags & udirq_pkg::EVENT_MASK;
  end

  // ----------------------------------------------------------------
  // endpoint and channel summaries
  // ----------------------------------------------------------------
  // no clear path from software: they follow their sources
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i || bus_reset_i)
      ep_sum <= '0;
    else
      ep_sum <= ep_irq_src_i
        & ien[udirq_pkg::EP_LSB +: udirq_pkg::EP_NUM];
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      dma_sum <= '0;
    else
      dma_sum <= dma_irq_src_i
        & ien[udirq_pkg::DMA_LSB +: udirq_pkg::DMA_NUM];
  end

  always_comb
  begin
    status_view = flags;
    status_view[udirq_pkg::BIT_SPEED] = high_speed_i;
    status_view[udirq_pkg::EP_LSB +: udirq_pkg::EP_NUM] = ep_sum;
    status_view[udirq_pkg::DMA_LSB +: udirq_pkg::DMA_NUM] = dma_sum;
  end

  // ----------------------------------------------------------------
  // interrupt output and endpoint reset strobes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else
      // summaries are masked once more, so a cleared enable or a bus reset
      // quiets the line without waiting for the summary flop to follow;
      // the speed bit never counts, its enable bit is always zero
      irq_o <= |(status_view & ien);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      ep_reset_o <= '0;
    // write-only: nothing is stored, each pulse lasts one cycle
    else if (wr_en && hit(paddr_i, udirq_pkg::EPRST_ADDR))
      ep_reset_o <= pwdata_i[6:0];
    else
      ep_reset_o <= '0;
  end

endmodule : udirq_ctrl

`default_nettype wire

/* File: sim/udirq_ctrl_properties.sv */
// Port-level checker for the interrupt block, attached by bind.
// Assumes every port is sampled on mclk_i; nrst_i is synchronous, low.
`timescale 1ns/1ps
`default_nettype none
module udirq_ctrl_properties #(
  parameter int SUSPEND_CYCLES = udirq_pkg::SUSPEND_CYCLES
) (
  input wire logic mclk_i, // clock
  input wire logic nrst_i, // reset
  input wire logic psel_i, // select
  input wire logic penable_i, // enable
  input wire logic pwrite_i, // write
  input wire logic [31:0] paddr_i, // address
  input wire logic [31:0] pwdata_i, // wdata
  input wire logic [31:0] prdata_o, // rdata
  input wire logic pready_o, // ready
  input wire logic high_speed_i, // speed
  input wire logic bus_reset_i, // bus reset
  input wire logic line_j_i, // idle j
  input wire logic sof_detect_i, // sof
  input wire logic usof_detect_i, // usof
  input wire logic [10:0] frame_number_i, // frame
  input wire logic irq_o, // irq
  input wire logic [6:0] ep_reset_o, // ep reset
  input wire logic suspended_o, // suspended
  input wire logic [2:0] ufrm_index_o, // index
  input wire logic [10:0] frame_count_o // frame
);
  // ----
  // helpers
  // ----
  int jcnt;
  logic wr_ep;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  assign wr_ep = psel_i && penable_i && pready_o && pwrite_i && paddr_i == udirq_pkg::EPRST_ADDR;
  // not reset: an over-long count only loosens the suspend check
  always_ff @(posedge mclk_i)
  begin
    jcnt <= line_j_i ? jcnt + 1 : 0;
  end
  sequence s_read;
    psel_i && penable_i && pready_o && !pwrite_i;
  endsequence
  property p_end_reset;
    $fell(bus_reset_i) |-> ##[1:3] irq_o;
  endproperty
  property p_in_reset;
    bus_reset_i [*3] |-> !irq_o;
  endproperty
  property p_eprst;
    1'b1 |=> ep_reset_o == ($past(wr_ep) ? $past(pwdata_i[6:0]) : 7'h00);
  endproperty
  property p_speed;
    s_read ##0 (paddr_i == udirq_pkg::FLAGS_ADDR) |-> prdata_o[0] == $past(high_speed_i);
  endproperty
  property p_wo_read;
    s_read ##0 (paddr_i == udirq_pkg::CLEAR_ADDR || paddr_i == udirq_pkg::EPRST_ADDR)
      |-> prdata_o == 32'h00000000;
  endproperty
  property p_ufrm;
    usof_detect_i && !sof_detect_i && !bus_reset_i
      |=> ufrm_index_o == 3'($past(ufrm_index_o) + 3'h1) && $stable(frame_count_o);
  endproperty
  property p_sof;
    sof_detect_i && high_speed_i && !bus_reset_i
      |=> ufrm_index_o == 3'h0 && frame_count_o == $past(frame_number_i);
  endproperty
  property p_susp;
    $rose(suspended_o) |-> jcnt >= SUSPEND_CYCLES;
  endproperty
  a_end_reset: assert property (p_end_reset)
    else $error("no interrupt after bus reset end");
  a_in_reset: assert property (p_in_reset)
    else $error("interrupt during bus reset");
  a_eprst: assert property (p_eprst)
    else $error("endpoint reset pulse wrong");
  a_speed: assert property (p_speed)
    else $error("speed bit wrong");
  a_wo_read: assert property (p_wo_read)
    else $error("write-only register read not zero");
  a_ufrm: assert property (p_ufrm)
    else $error("microframe index not incremented");
  a_sof: assert property (p_sof)
    else $error("frame start did not load counters");
  a_susp: assert property (p_susp)
    else $error("suspend before idle time");
endmodule : udirq_ctrl_properties
bind udirq_ctrl udirq_ctrl_properties #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) udirq_ctrl_properties_inst (
  .mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .high_speed_i, .bus_reset_i, .line_j_i, .sof_detect_i, .usof_detect_i,
  .frame_number_i, .irq_o, .ep_reset_o, .suspended_o, .ufrm_index_o, .frame_count_o
);
`default_nettype wire

/* File: sim/udirq_host_model.sv */
// Behavioural host and line: bus resets, frame starts, idle and wake.
// Assumes one caller at a time; every task ends at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module udirq_host_model (
  input wire logic mclk_i, // clock
  output logic bus_reset_o = 1'b0, // bus reset
  output logic line_j_o = 1'b0, // line idle
  output logic wake_o = 1'b0, // activity
  output logic sof_o = 1'b0, // frame start
  output logic usof_o = 1'b0, // microframe start
  output logic [10:0] fnum_o = 11'h000 // frame field
);
  task automatic bus_reset();
    @(posedge mclk_i);
    bus_reset_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    bus_reset_o <= 1'b0;
    repeat (3) @(negedge mclk_i);
  endtask : bus_reset
  task automatic frame(input logic sof, input logic usof, input logic [10:0] num);
    @(posedge mclk_i);
    sof_o <= sof;
    usof_o <= usof;
    fnum_o <= num;
    @(posedge mclk_i);
    sof_o <= 1'b0;
    usof_o <= 1'b0;
    // field is stale after the token, so show something else
    fnum_o <= ~num;
    repeat (3) @(negedge mclk_i);
  endtask : frame
  task automatic idle();
    @(posedge mclk_i);
    line_j_o <= 1'b1;
    @(negedge mclk_i);
  endtask : idle
  task automatic wake();
    @(posedge mclk_i);
    line_j_o <= 1'b0;
    wake_o <= 1'b1;
    repeat (2) @(posedge mclk_i);
    wake_o <= 1'b0;
    @(negedge mclk_i);
  endtask : wake
endmodule : udirq_host_model
`default_nettype wire

/* File: sim/usb_device_irq_control_tb_top.sv */
// Testbench: APB register sequences with line events from the host model.
// Assumes a 200 MHz clock and a shortened suspend count.
`timescale 1ns/1ps
`default_nettype none
module usb_device_irq_control_tb_top;
  localparam int SUSP = 20;
  localparam logic [31:0] IEN = udirq_pkg::IEN_ADDR;
  localparam logic [31:0] FL = udirq_pkg::FLAGS_ADDR;
  localparam logic [31:0] CL = udirq_pkg::CLEAR_ADDR;
  localparam logic [31:0] EPR = udirq_pkg::EPRST_ADDR;
  logic mclk_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic nrst_i;
  logic hs = 1'b0, hrd = 1'b0, rrs = 1'b0, ssof = 1'b0, susof = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic [6:0] ep_src = 7'h00, ep_rst;
  logic [5:0] dma_src = 6'h00;
  logic pready, pslverr, irq, wake_irq, susp, e, bus_rst, line_j, wake_act, sof, usof;
  logic [2:0] ufrm;
  logic [10:0] fcnt, fnum;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2.5 mclk_i = ~mclk_i;
  udirq_host_model udirq_host_model_inst (.mclk_i(mclk_i), .bus_reset_o(bus_rst),
    .line_j_o(line_j), .wake_o(wake_act), .sof_o(sof), .usof_o(usof), .fnum_o(fnum));
  udirq_ctrl #(.SUSPEND_CYCLES(SUSP)) udirq_ctrl_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .high_speed_i(hs), .bus_reset_i(bus_rst), .line_j_i(line_j), .wake_activity_i(wake_act),
    .sof_detect_i(sof), .sof_synth_i(ssof), .usof_detect_i(usof), .usof_synth_i(susof),
    .frame_number_i(fnum), .host_resume_done_i(hrd), .remote_resume_sending_i(rrs),
    .ep_irq_src_i(ep_src), .dma_irq_src_i(dma_src), .irq_o(irq), .wake_irq_o(wake_irq),
    .ep_reset_o(ep_rst), .suspended_o(susp), .ufrm_index_o(ufrm), .frame_count_o(fcnt));
  // ----
  // tasks
  // ----
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", s, x, g);
    end
  endtask : chk
  // request held until the rising edge that samples pready high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // return off the edge so later pin checks never race the clock
    @(negedge mclk_i);
  endtask : apb
  task automatic rdc(input string s, input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(s, x, q);
  endtask : rdc
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_errors++;
      conclude();
    end
  end
  initial
  begin
    // the step from unknown to low also resets the clockless wake flop
    nrst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rdc("ien", IEN, 32'h0);
    rdc("flags", FL, 32'h0);
    udirq_host_model_inst.bus_reset();
    rdc("ien", IEN, 32'h10);
    rdc("flags", FL, 32'h10);
    chk("irq", 32'h1, irq);
    apb(1'b1, CL, 32'h10);
    rdc("flags", FL, 32'h0);
    chk("irq", 32'h0, irq);
    apb(1'b1, IEN, 32'hFFFFFFFF);
    rdc("ien", IEN, 32'h7E007FFE);
    @(posedge mclk_i);
    hs <= 1'b1;
    udirq_host_model_inst.frame(1'b1, 1'b1, 11'h123);
    rdc("flags", FL, 32'h09);
    apb(1'b1, CL, 32'h0);
    rdc("flags", FL, 32'h09);
    apb(1'b1, CL, 32'h08);
    udirq_host_model_inst.frame(1'b0, 1'b1, 11'h0);
    udirq_host_model_inst.frame(1'b0, 1'b1, 11'h0);
    rdc("flags", FL, 32'h05);
    chk("ufrm", 32'h2, ufrm);
    chk("fcnt", 32'h123, fcnt);
    udirq_host_model_inst.frame(1'b1, 1'b0, 11'h5A5);
    chk("ufrm", 32'h0, ufrm);
    chk("fcnt", 32'h5A5, fcnt);
    rdc("flags", FL, 32'h0D);
    apb(1'b1, CL, 32'hFE);
    @(posedge mclk_i);
    ssof <= 1'b1;
    susof <= 1'b1;
    @(posedge mclk_i);
    ssof <= 1'b0;
    susof <= 1'b0;
    rdc("flags", FL, 32'h09);
    @(posedge mclk_i);
    susof <= 1'b1;
    @(posedge mclk_i);
    susof <= 1'b0;
    rdc("flags", FL, 32'h0D);
    chk("ufrm", 32'h0, ufrm);
    apb(1'b1, CL, 32'hFE);
    @(posedge mclk_i);
    hrd <= 1'b1;
    @(posedge mclk_i);
    hrd <= 1'b0;
    rrs <= 1'b1;
    ep_src <= 7'h41;
    dma_src <= 6'h21;
    rdc("flags", FL, 32'h420041C1);
    apb(1'b1, CL, 32'hFFFFFFFF);
    apb(1'b1, FL, 32'h0);
    rdc("flags", FL, 32'h42004181);
    @(posedge mclk_i);
    rrs <= 1'b0;
    ep_src <= 7'h00;
    dma_src <= 6'h00;
    apb(1'b1, CL, 32'h80);
    rdc("flags", FL, 32'h1);
    apb(1'b1, IEN, 32'h0);
    @(posedge mclk_i);
    ep_src <= 7'h7F;
    dma_src <= 6'h3F;
    hrd <= 1'b1;
    @(posedge mclk_i);
    hrd <= 1'b0;
    rdc("flags", FL, 32'h41);
    chk("irq", 32'h0, irq);
    apb(1'b1, EPR, 32'h55);
    chk("ep_rst", 32'h55, ep_rst);
    rdc("eprst", EPR, 32'h0);
    chk("ep_rst", 32'h0, ep_rst);
    apb(1'b0, IEN + 32'h100, 32'h0);
    chk("pslverr", 32'h1, e);
    apb(1'b1, CL, 32'hFE);
    apb(1'b1, IEN, 32'h22);
    udirq_host_model_inst.idle();
    repeat (SUSP / 2) @(negedge mclk_i);
    chk("susp", 32'h0, susp);
    repeat (SUSP) @(negedge mclk_i);
    chk("susp", 32'h1, susp);
    rdc("flags", FL, 32'h3);
    chk("irq", 32'h1, irq);
    udirq_host_model_inst.wake();
    chk("wake", 32'h1, wake_irq);
    rdc("flags", FL, 32'h23);
    apb(1'b1, CL, 32'h20);
    chk("wake", 32'h0, wake_irq);
    udirq_host_model_inst.bus_reset();
    rdc("ien", IEN, 32'h10);
    conclude();
  end
endmodule : usb_device_irq_control_tb_top
`default_nettype wire
